// >>> hw/rmsp_defs.svh
// Constants for the relay module serial port host controller
`ifndef RMSP_DEFS_SVH
`define RMSP_DEFS_SVH
// ==========================================================
// Timing
`define RMSP_CLK_NS 50
`define RMSP_HALF_NS 500
`define RMSP_HALF_CYC ((`RMSP_HALF_NS + `RMSP_CLK_NS - 1) / `RMSP_CLK_NS)
`define RMSP_STAT_NS 1000
`define RMSP_STAT_CYC ((`RMSP_STAT_NS + `RMSP_CLK_NS - 1) / `RMSP_CLK_NS)
// ==========================================================
// Address handler values
`define RMSP_ADDR_DATA 16'h0001
`define RMSP_ADDR_ID 16'h0000
`define RMSP_ADDR_STAT 16'h0002
`define RMSP_ADDR_PARK 16'hFFFF
`define RMSP_SLOT_NONE 16'h0000
// ==========================================================
// Frame lengths and widths
`define RMSP_BITS_SEL 6'h10
`define RMSP_BITS_DATA 6'h20
`define RMSP_CNT_W 8
`define RMSP_PAD16 16'h0000
`define RMSP_WORD0 32'h0000_0000
`endif

// >>> hw/rmsp_pkg.sv
// Types shared by the relay module serial port host controller
package rmsp_pkg;
    // Operation requested by the user
    typedef enum logic [1:0] {
        RMSP_OP_WRITE = 2'b00,
        RMSP_OP_ID = 2'b01,
        RMSP_OP_STAT = 2'b10
    } rmsp_op_type;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SEL_LO = 4'b0001,
        ST_SEL_SH = 4'b0010,
        ST_SEL_HI = 4'b0011,
        ST_ADR_SH = 4'b0100,
        ST_DA_LO = 4'b0101,
        ST_DAT_SH = 4'b0110,
        ST_STAT = 4'b0111,
        ST_DA_HI = 4'b1000,
        ST_PARK_SH = 4'b1001
    } rmsp_state_type;
endpackage

// >>> hw/rmsp_shift_if.sv
// Link between the sequencer and the bit shifter
interface rmsp_shift_if;
    logic start;
    logic [5:0] nbits;
    logic [31:0] tx;
    logic [31:0] rx;
    logic done;
    logic sclk;
    logic mosi;
    logic miso;
    modport ctrl (output start, nbits, tx, miso, input rx, done, sclk, mosi);
    modport eng (input start, nbits, tx, miso, output rx, done, sclk, mosi);
endinterface

// >>> hw/rmsp_sync.sv
// Two-flop synchroniser for pin inputs
module rmsp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk, // Clock
    input wire logic i_rst_b, // Sync reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic [W-1:0] i_d, // Asynchronous input
    output logic [W-1:0] o_q // Synchronised output
);
    logic [W-1:0] s1_reg; // First stage, read only by second
    logic [W-1:0] s2_reg; // Second stage
    // ==========================================================
    // Two stages
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else if (i_ce) begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
        end
    end
    assign o_q = s2_reg;
endmodule

// >>> hw/rmsp_shifter.sv
// Serial bit engine: makes the idle-high clock, shifts MSB first
`include "rmsp_defs.svh"
module rmsp_shifter #(
    parameter int unsigned HALF_CYC = `RMSP_HALF_CYC
) (
    input wire logic i_mclk, // Clock
    input wire logic i_rst_b, // Sync reset, active low
    input wire logic i_ce, // Clock enable
    rmsp_shift_if.eng s // Sequencer side
);
    logic active_reg, active_next; // Frame in progress
    logic sclk_reg, sclk_next; // Serial clock, idles high
    logic mosi_reg, mosi_next; // Serial data out
    logic done_reg, done_next; // One-cycle end pulse
    logic [31:0] sr_reg, sr_next; // Transmit shifter
    logic [31:0] rx_reg, rx_next; // Receive shifter
    logic [5:0] bits_reg, bits_next; // Bits left
    logic [`RMSP_CNT_W-1:0] cnt_reg, cnt_next; // Half period count
    // ==========================================================
    // Next state
    always_comb begin
        active_next = active_reg;
        sclk_next = sclk_reg;
        mosi_next = mosi_reg;
        done_next = 1'b0;
        sr_next = sr_reg;
        rx_next = rx_reg;
        bits_next = bits_reg;
        cnt_next = cnt_reg;
        if (!active_reg) begin
            // Data set up and clock driven low in the same cycle
            if (s.start) begin
                active_next = 1'b1;
                sr_next = s.tx;
                bits_next = s.nbits;
                sclk_next = 1'b0;
                mosi_next = s.tx[31];
                cnt_next = '0;
            end
        end else if (cnt_reg == `RMSP_CNT_W'(HALF_CYC - 1)) begin
            cnt_next = '0;
            if (!sclk_reg) begin
                // Rising edge captures the bit
                sclk_next = 1'b1;
            end else begin
                // Sample late in high phase, after device update
                rx_next = {rx_reg[30:0], s.miso};
                sr_next = {sr_reg[30:0], 1'b0};
                bits_next = bits_reg - 6'h01;
                if (bits_reg == 6'h01) begin
                    active_next = 1'b0; // Clock left high
                    done_next = 1'b1;
                end else begin
                    sclk_next = 1'b0;
                    mosi_next = sr_reg[30];
                end
            end
        end else begin
            cnt_next = cnt_reg + `RMSP_CNT_W'(1);
        end
    end
    // ==========================================================
    // Registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            active_reg <= 1'b0;
            sclk_reg <= 1'b1;
            mosi_reg <= 1'b1;
            done_reg <= 1'b0;
            sr_reg <= `RMSP_WORD0;
            rx_reg <= `RMSP_WORD0;
            bits_reg <= '0;
            cnt_reg <= '0;
        end else if (i_ce) begin
            active_reg <= active_next;
            sclk_reg <= sclk_next;
            mosi_reg <= mosi_next;
            done_reg <= done_next;
            sr_reg <= sr_next;
            rx_reg <= rx_next;
            bits_reg <= bits_next;
            cnt_reg <= cnt_next;
        end
    end
    assign s.sclk = sclk_reg;
    assign s.mosi = mosi_reg;
    assign s.done = done_reg;
    assign s.rx = rx_reg;
    // ==========================================================
    // Checks
    a_data_stable_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(sclk_reg) |-> $stable(mosi_reg))
        else $error("data moved on clock rise");
    a_clock_low_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $fell(sclk_reg) |=> !sclk_reg)
        else $error("clock low phase too short");
endmodule

// >>> hw/rmsp_host.sv
// Host controller for the relay module serial port
`include "rmsp_defs.svh"
module rmsp_host #(
    parameter int unsigned HALF_CYC = `RMSP_HALF_CYC, // Half clock period
    parameter int unsigned STAT_CYC = `RMSP_STAT_CYC // Status settle time
) (
    input wire logic i_mclk, // 20 MHz clock
    input wire logic i_rst_b, // Sync reset, active low
    input wire logic i_ce, // Clock enable, freezes all
    input wire logic i_req, // Start request
    input wire rmsp_pkg::rmsp_op_type i_op, // Operation
    input wire logic [15:0] i_slot_word, // Slot and chassis number
    input wire logic [31:0] i_wdata, // Relay data to write
    input wire logic i_park, // Park address after access
    input wire logic i_host_serial_out, // Pin from module
    output logic o_ready, // Idle, takes a request
    output logic o_done, // Operation finished pulse
    output logic [31:0] o_rdata, // Identification word read
    output logic o_status, // Relay status bit read
    output logic o_host_serial_in, // Pin: serial data to module
    output logic o_host_serial_clock, // Pin: serial clock
    output logic o_data_not_address, // Pin: data/address
    output logic o_slot_controller_select_n // Pin: slot controller select
);
    import rmsp_pkg::*;

    // ==========================================================
    // Helper functions
    // Address handler value for each operation
    function automatic logic [15:0] addr_of(input rmsp_op_type op);
        case (op)
            RMSP_OP_WRITE: addr_of = `RMSP_ADDR_DATA;
            RMSP_OP_ID: addr_of = `RMSP_ADDR_ID;
            RMSP_OP_STAT: addr_of = `RMSP_ADDR_STAT;
            default: addr_of = `RMSP_ADDR_PARK;
        endcase
    endfunction

    // 16-bit word placed at the MSB end of the shifter
    function automatic logic [31:0] left16(input logic [15:0] w);
        left16 = {w, `RMSP_PAD16};
    endfunction

    // ==========================================================
    // Declarations
    rmsp_shift_if sif (); // Link to bit engine
    logic miso_sync; // Module output after two flops
    rmsp_state_type state_reg, state_next; // Sequencer state
    rmsp_op_type op_reg, op_next; // Latched operation
    logic [15:0] slot_reg, slot_next; // Latched slot word
    logic [31:0] wdata_reg, wdata_next; // Latched relay data
    logic park_reg, park_next; // Park after access
    logic final_reg, final_next; // Zero slot word phase
    logic [`RMSP_CNT_W-1:0] wait_reg, wait_next; // Settle counter
    logic sel_n_reg, sel_n_next; // Slot controller select
    logic dna_reg, dna_next; // Data/address line
    logic ready_reg, ready_next; // Idle flag
    logic done_reg, done_next; // Done pulse
    logic [31:0] rdata_reg, rdata_next; // ID word
    logic status_reg, status_next; // Status bit
    logic start_reg, start_next; // Shift start pulse
    logic [5:0] nbits_reg, nbits_next; // Shift length
    logic [31:0] tx_reg, tx_next; // Shift word

    // ==========================================================
    // Pin input synchroniser
    rmsp_sync #(
        .W(1)
    ) u_sync (
        .i_clk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_d(i_host_serial_out),
        .o_q(miso_sync)
    );

    // ==========================================================
    // Bit engine
    rmsp_shifter #(
        .HALF_CYC(HALF_CYC)
    ) u_shift (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .s(sif.eng)
    );
    assign sif.start = start_reg;
    assign sif.nbits = nbits_reg;
    assign sif.tx = tx_reg;
    assign sif.miso = miso_sync;

    // ==========================================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        slot_next = slot_reg;
        wdata_next = wdata_reg;
        park_next = park_reg;
        final_next = final_reg;
        wait_next = wait_reg;
        sel_n_next = sel_n_reg;
        dna_next = dna_reg;
        ready_next = ready_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        status_next = status_reg;
        start_next = 1'b0;
        nbits_next = nbits_reg;
        tx_next = tx_reg;
        case (state_reg)
            ST_IDLE: begin
                // Clock, D/A and select idle high; take a new request
                if (i_req) begin
                    op_next = i_op;
                    slot_next = i_slot_word;
                    wdata_next = i_wdata;
                    park_next = i_park;
                    final_next = 1'b0;
                    ready_next = 1'b0;
                    sel_n_next = 1'b0;
                    wait_next = '0;
                    state_next = ST_SEL_LO;
                end
            end
            ST_SEL_LO: begin
                // Select held low, then slot word shifts
                if (wait_reg == `RMSP_CNT_W'(HALF_CYC - 1)) begin
                    start_next = 1'b1;
                    nbits_next = `RMSP_BITS_SEL;
                    if (final_reg) begin
                        tx_next = left16(`RMSP_SLOT_NONE);
                    end else begin
                        tx_next = left16(slot_reg);
                    end
                    state_next = ST_SEL_SH;
                end else begin
                    wait_next = wait_reg + `RMSP_CNT_W'(1);
                end
            end
            ST_SEL_SH: begin
                // Release select once the word is in
                if (sif.done) begin
                    sel_n_next = 1'b1;
                    wait_next = '0;
                    state_next = ST_SEL_HI;
                end
            end
            ST_SEL_HI: begin
                // Module now selected, or all released
                if (wait_reg == `RMSP_CNT_W'(HALF_CYC - 1)) begin
                    if (final_reg) begin
                        ready_next = 1'b1;
                        done_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        // Address first, clock idle high since the slot word shifted
                        start_next = 1'b1;
                        nbits_next = `RMSP_BITS_SEL;
                        tx_next = left16(addr_of(op_reg));
                        state_next = ST_ADR_SH;
                    end
                end else begin
                    wait_next = wait_reg + `RMSP_CNT_W'(1);
                end
            end
            ST_ADR_SH: begin
                // Address loaded: lower D/A to enable register
                if (sif.done) begin
                    dna_next = 1'b0;
                    wait_next = '0;
                    state_next = ST_DA_LO;
                end
            end
            ST_DA_LO: begin
                // Settle, then data phase or status sample
                if (wait_reg == `RMSP_CNT_W'(HALF_CYC - 1)) begin
                    wait_next = '0;
                    if (op_reg == RMSP_OP_STAT) begin
                        state_next = ST_STAT;
                    end else begin
                        start_next = 1'b1;
                        nbits_next = `RMSP_BITS_DATA;
                        tx_next = wdata_reg;
                        state_next = ST_DAT_SH;
                    end
                end else begin
                    wait_next = wait_reg + `RMSP_CNT_W'(1);
                end
            end
            ST_DAT_SH: begin
                // 32 bits written or read
                if (sif.done) begin
                    if (op_reg == RMSP_OP_ID) begin
                        rdata_next = sif.rx;
                    end
                    dna_next = 1'b1;
                    wait_next = '0;
                    state_next = ST_DA_HI;
                end
            end
            ST_STAT: begin
                // No clock pulses; wait out sync and settle
                if (wait_reg == `RMSP_CNT_W'(STAT_CYC - 1)) begin
                    status_next = miso_sync;
                    dna_next = 1'b1;
                    wait_next = '0;
                    state_next = ST_DA_HI;
                end else begin
                    wait_next = wait_reg + `RMSP_CNT_W'(1);
                end
            end
            ST_DA_HI: begin
                // Optional park, else deselect
                if (wait_reg == `RMSP_CNT_W'(HALF_CYC - 1)) begin
                    wait_next = '0;
                    if (park_reg) begin
                        start_next = 1'b1;
                        nbits_next = `RMSP_BITS_SEL;
                        tx_next = left16(`RMSP_ADDR_PARK);
                        state_next = ST_PARK_SH;
                    end else begin
                        sel_n_next = 1'b0;
                        final_next = 1'b1;
                        state_next = ST_SEL_LO;
                    end
                end else begin
                    wait_next = wait_reg + `RMSP_CNT_W'(1);
                end
            end
            ST_PARK_SH: begin
                // Parked: deselect and write zero slot word
                if (sif.done) begin
                    sel_n_next = 1'b0;
                    final_next = 1'b1;
                    wait_next = '0;
                    state_next = ST_SEL_LO;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Sequencer registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            op_reg <= RMSP_OP_WRITE;
            slot_reg <= `RMSP_SLOT_NONE;
            wdata_reg <= `RMSP_WORD0;
            park_reg <= 1'b0;
            final_reg <= 1'b0;
            wait_reg <= '0;
            sel_n_reg <= 1'b1;
            dna_reg <= 1'b1;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            rdata_reg <= `RMSP_WORD0;
            status_reg <= 1'b0;
            start_reg <= 1'b0;
            nbits_reg <= '0;
            tx_reg <= `RMSP_WORD0;
        end else if (i_ce) begin
            state_reg <= state_next;
            op_reg <= op_next;
            slot_reg <= slot_next;
            wdata_reg <= wdata_next;
            park_reg <= park_next;
            final_reg <= final_next;
            wait_reg <= wait_next;
            sel_n_reg <= sel_n_next;
            dna_reg <= dna_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            status_reg <= status_next;
            start_reg <= start_next;
            nbits_reg <= nbits_next;
            tx_reg <= tx_next;
        end
    end

    // ==========================================================
    // Outputs
    assign o_ready = ready_reg;
    assign o_done = done_reg;
    assign o_rdata = rdata_reg;
    assign o_status = status_reg;
    assign o_host_serial_in = sif.mosi;
    assign o_host_serial_clock = sif.sclk;
    assign o_data_not_address = dna_reg;
    assign o_slot_controller_select_n = sel_n_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    a_sel_fall_idle: assert property ($fell(sel_n_reg) |-> sif.sclk && dna_reg)
        else $error("select fell with clock or D/A low");
    a_sel_low_shift: assert property (state_reg == ST_SEL_SH |-> !sel_n_reg)
        else $error("slot word shifted with select high");
    a_sel_rise_clock: assert property ($rose(sel_n_reg) |-> sif.sclk)
        else $error("select rose with clock low");
    a_addr_da_high: assert property (state_reg == ST_ADR_SH |-> dna_reg && sel_n_reg)
        // Module stays selected: slot controller select held high
        else $error("address shifted with D/A low");
    a_data_da_low: assert property (state_reg == ST_DAT_SH |-> !dna_reg)
        else $error("data shifted with D/A high");
    a_da_edge_clock: assert property ($changed(dna_reg) |-> sif.sclk)
        else $error("D/A moved while clock low");
    a_zero_word: assert property (state_reg == ST_SEL_LO && final_reg && start_next
        |=> tx_reg == `RMSP_WORD0)
        else $error("closing slot word not zero");
    a_stat_no_clock: assert property (state_reg == ST_STAT |-> sif.sclk)
        else $error("clock pulsed during status read");
    a_addr_before_data: assert property ($fell(dna_reg) |-> $past(state_reg) == ST_ADR_SH)
        else $error("D/A fell without address load");
    a_done_ready: assert property (done_reg |-> ready_reg && sel_n_reg && dna_reg)
        else $error("done with lines not idle");

    c_write_done: cover property (op_reg == RMSP_OP_WRITE && done_reg);
    c_id_done: cover property (op_reg == RMSP_OP_ID && done_reg);
    c_stat_done: cover property (op_reg == RMSP_OP_STAT && done_reg);
    c_park_done: cover property (park_reg && done_reg);
endmodule

// >>> test/rmsp_dev.sv
// Behavioural slot controller and relay module on the far side of the host
module rmsp_dev #(
    parameter logic [7:0] SLOT = 8'h05, // Slot of this module, chassis ignored
    parameter logic [31:0] ID_WORD = 32'h5A3C_96E1 // Arbitrary identification word
) (
    input wire logic i_sclk, // Serial clock from host
    input wire logic i_mosi, // Serial data from host
    input wire logic i_da, // Data/address line
    input wire logic i_sel_n, // Slot controller select
    input wire logic i_busy, // Relays switching
    output logic o_miso, // Serial data to host
    output logic [31:0] o_relay, // Relay drive word
    output logic [15:0] o_slot_word // Slot-select register
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ss = 1'b0; // Module select
    logic [15:0] addr = 16'hFFFF; // Address handler
    logic [31:0] sh = 32'h0000_0000; // Data shift register
    logic [5:0] cnt = 6'h00; // Identification bits sent
    logic idb = 1'b0; // Identification bit on the line
    initial begin
        o_relay = 32'h0000_0000;
        o_slot_word = 16'h0000;
    end
    // ==========================================================
    // Slot controller: select low drops the module and restarts readout
    always @(negedge i_sel_n) begin
        ss = 1'b0;
        cnt = 6'h00;
        idb = 1'b0;
    end
    // Select high picks the written slot in any chassis
    always @(posedge i_sel_n) ss = (o_slot_word[7:0] == SLOT);
    // ==========================================================
    // Capture on the rising clock; other addresses, parking too, touch nothing
    always @(posedge i_sclk) begin
        if (!i_sel_n) o_slot_word = {o_slot_word[14:0], i_mosi};
        else if (ss && i_da) addr = {addr[14:0], i_mosi};
        else if (ss && addr == 16'h0001) sh = {sh[30:0], i_mosi};
    end
    // Identification bits change on the falling clock, zeros after 32
    always @(negedge i_sclk) if (ss && !i_da && addr == 16'h0000) begin
        idb = (cnt < 6'h20) ? ID_WORD[5'h1F - cnt[4:0]] : 1'b0;
        if (cnt < 6'h20) cnt = cnt + 6'h01;
    end
    // Data/address high ends the write and latches the relays
    always @(posedge i_da) if (ss && addr == 16'h0001) o_relay = sh;
    // Open-collector line: pulled high unless the module drives it
    assign o_miso = (!ss || i_da) ? 1'b1 : (addr == 16'h0000) ? idb :
        (addr == 16'h0002) ? !i_busy : 1'b1;
endmodule

// >>> test/testbench.sv
// Self-checking bench for the relay module serial port host controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rmsp_pkg::*;
    typedef struct {
        rmsp_op_type op;
        logic [15:0] slot;
        logic [31:0] wd;
        logic park;
        logic busy;
        logic [31:0] exp;
    } rmsp_row_type;
    localparam logic [31:0] IDW = 32'h5A3C_96E1; // Arbitrary identification word
    logic i_mclk = 1'b0, i_rst_b = 1'b0, i_req = 1'b0, i_park = 1'b0, busy = 1'b0;
    logic ce = 1'b1; // Clock enable to the host
    logic [4:0] pins; // Pin levels held while frozen
    rmsp_op_type i_op = RMSP_OP_WRITE; // Requested operation
    logic [15:0] i_slot_word = 16'h0000; // Slot word
    logic [31:0] i_wdata = 32'h0000_0000; // Relay data
    logic ready, done, stat, sin, sclk, da, sel_n, miso;
    logic [31:0] rdata, relay, keep;
    logic [15:0] slot_reg;
    int miscompares = 0, n_compared = 0, cycles = 0;
    rmsp_row_type r;
    rmsp_row_type rows [8] = '{
        '{RMSP_OP_WRITE, 16'h0005, 32'h830F_0000, 1'b0, 1'b0, 32'h830F_0000},
        '{RMSP_OP_WRITE, 16'h0905, 32'h1234_5678, 1'b1, 1'b0, 32'h1234_5678},
        '{RMSP_OP_ID, 16'h0005, 32'h0000_0000, 1'b0, 1'b0, IDW},
        '{RMSP_OP_ID, 16'h0006, 32'h0000_0000, 1'b0, 1'b0, 32'hFFFF_FFFF},
        '{RMSP_OP_STAT, 16'h0005, 32'h0000_0000, 1'b0, 1'b1, 32'h0000_0000},
        '{RMSP_OP_STAT, 16'h0005, 32'h0000_0000, 1'b1, 1'b0, 32'h0000_0001},
        '{RMSP_OP_WRITE, 16'h0006, 32'hDEAD_0001, 1'b0, 1'b0, 32'h1234_5678},
        '{RMSP_OP_ID, 16'h0005, 32'h0000_0000, 1'b1, 1'b0, IDW}};
    rmsp_host #(.HALF_CYC(3), .STAT_CYC(4)) DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_ce(ce), .i_req(i_req), .i_op(i_op), .i_slot_word(i_slot_word),
        .i_wdata(i_wdata), .i_park(i_park), .i_host_serial_out(miso), .o_ready(ready),
        .o_done(done), .o_rdata(rdata), .o_status(stat), .o_host_serial_in(sin),
        .o_host_serial_clock(sclk), .o_data_not_address(da),
        .o_slot_controller_select_n(sel_n));
    rmsp_dev dev (.i_sclk(sclk), .i_mosi(sin), .i_da(da), .i_sel_n(sel_n), .i_busy(busy),
        .o_miso(miso), .o_relay(relay), .o_slot_word(slot_reg));
    // Clock at 20 MHz
    always #25 i_mclk = ~i_mclk;
    // Cut a hang short
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    // ==========================================================
    // Report a mismatch
    task automatic fail(string m);
        miscompares++;
        n_compared++;
        $display("FAIL t=%0t %s", $time, m);
    endtask
    // Print the counts and the verdict, then stop
    task automatic results();
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Issue one request on the falling edge
    task automatic issue(rmsp_row_type x);
        @(negedge i_mclk);
        i_op = x.op;
        i_slot_word = x.slot;
        i_wdata = x.wd;
        i_park = x.park;
        busy = x.busy;
        i_req = 1'b1;
        @(negedge i_mclk);
        i_req = 1'b0;
    endtask
    // Wait for the done pulse under a bound
    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 4000) begin
            @(negedge i_mclk);
            k++;
        end
        if (k == 4000) fail("no done");
    endtask
    // Idle levels of ready, clock, D/A and select
    task automatic idle_chk();
        if ({ready, sclk, da, sel_n} !== 4'hF) fail("idle lines"); else n_compared++;
    endtask
    // ==========================================================
    initial begin
        repeat (5) @(negedge i_mclk);
        i_rst_b = 1'b1;
        if ({done, rdata, stat, sin} !== {1'b0, 32'h0000_0000, 1'b0, 1'b1}) fail("reset");
        else n_compared++;
        idle_chk();
        foreach (rows[i]) begin
            r = rows[i];
            issue(r);
            wait_done();
            if (r.op == RMSP_OP_WRITE && relay !== r.exp) fail("relay"); else n_compared++;
            if (r.op == RMSP_OP_ID && rdata !== r.exp) fail("id word"); else n_compared++;
            if (r.op == RMSP_OP_STAT && stat !== r.exp[0]) fail("status"); else n_compared++;
            if (slot_reg !== 16'h0000) fail("slot word left"); else n_compared++;
            idle_chk();
        end
        // Reset in mid-write, then a busy-time request is refused
        issue(rows[0]);
        repeat (150) @(negedge i_mclk);
        i_rst_b = 1'b0;
        repeat (5) @(negedge i_mclk);
        i_rst_b = 1'b1;
        idle_chk();
        keep = relay;
        issue(rows[2]);
        issue(rows[6]);
        wait_done();
        if (rdata !== IDW) fail("id after abort"); else n_compared++;
        if (relay !== keep) fail("refused write"); else n_compared++;
        // Clock enable low in mid-frame freezes every pin, then the write completes
        issue(rows[0]);
        repeat (60) @(negedge i_mclk);
        ce = 1'b0;
        pins = {ready, sclk, sin, da, sel_n};
        repeat (40) @(negedge i_mclk);
        if ({ready, sclk, sin, da, sel_n} !== pins) fail("freeze"); else n_compared++;
        ce = 1'b1;
        wait_done();
        if (relay !== rows[0].exp) fail("relay after freeze"); else n_compared++;
        results();
    end
endmodule
